// ---- pkg/svc_timing_pkg.sv ----
package svc_timing_pkg;

  // ----------------------------------------------------------------
  // Widths and carriers
  // ----------------------------------------------------------------
  localparam int CNT_W   = 10;
  localparam int WS_W    = 2;
  localparam int ROT_W   = 5;
  localparam int PIN_EXT = 0;
  localparam int PIN_NMI = 1;

  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_LAT = 3'h2, ST_SERV = 3'h4} state_t;
  typedef enum logic [2:0] {
    SVC_NONE = 3'h0, SVC_NMI = 3'h1, SVC_DMA = 3'h2, SVC_MACRO = 3'h3, SVC_EXT = 3'h4, SVC_INT = 3'h5
  } svc_t;
  typedef enum logic [1:0] {
    DMA_SINGLE_STEP = 2'h0, DMA_DEMAND = 2'h1, DMA_BURST = 2'h2, DMA_SINGLE_XFER = 2'h3
  } dma_mode_t;
  typedef enum logic [1:0] {
    MAC_SFR_MEM = 2'h0, MAC_MEM_SFR = 2'h1, MAC_SRCH_SFR_MEM = 2'h2, MAC_SRCH_MEM_SFR = 2'h3
  } macro_kind_t;
  typedef enum logic [1:0] {INS_PLAIN = 2'h0, INS_ROT_REG = 2'h1, INS_ROT_MEM = 2'h2} instr_kind_t;

  // Wait states come from the wait_control_register field of the accessed space.
  typedef struct packed {
    logic [WS_W-1:0] wait_states;
    logic            ram_enable;
  } cfg_t;

  typedef struct packed {
    logic             start;
    instr_kind_t      kind;
    logic             wide;
    logic [1:0]       mod;
    logic [ROT_W-1:0] rot_count;
    cnt_t             clocks;
  } instr_t;

  typedef struct packed {
    logic      req;
    dma_mode_t mode;
    logic      word;
  } dma_t;

  typedef struct packed {
    logic        req;
    macro_kind_t kind;
    logic        word;
  } macro_t;

  // ----------------------------------------------------------------
  // Clock counts
  // ----------------------------------------------------------------
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam cnt_t CNT_ZERO       = 10'h000;
  localparam cnt_t CNT_ONE        = 10'h001;
  localparam cnt_t W_X1           = 10'h001;
  localparam cnt_t W_X2           = 10'h002;
  localparam cnt_t W_X4           = 10'h004;
  localparam cnt_t EA_SHORT       = 10'h003;
  localparam cnt_t EA_LONG        = 10'h004;
  localparam cnt_t LAT_MASKABLE   = 10'h01B;
  localparam cnt_t LAT_NMI        = 10'h012;
  localparam cnt_t LAT_DMA        = 10'h01D;
  localparam cnt_t LAT_DMA_SINGLE = 10'h01F;
  localparam cnt_t VEC_BASE       = 10'h03A;
  localparam cnt_t VEC_PER_W      = 10'h00A;
  localparam cnt_t CTX_CLK        = 10'h01B;
  localparam cnt_t PIN_BASE       = 10'h03E;
  localparam cnt_t PIN_PER_W      = 10'h006;
  localparam cnt_t DMA_SS_B       = 10'h014;
  localparam cnt_t DMA_SS_W       = 10'h018;
  localparam cnt_t DMA_DR_B       = 10'h00F;
  localparam cnt_t DMA_DR_W       = 10'h011;
  localparam cnt_t DMA_BU         = 10'h00C;
  localparam cnt_t DMA_SX_B       = 10'h021;
  localparam cnt_t DMA_SX_W       = 10'h023;
  localparam cnt_t MAC_SM_B       = 10'h018;
  localparam cnt_t MAC_SM_B_NR    = 10'h013;
  localparam cnt_t MAC_SM_W       = 10'h01A;
  localparam cnt_t MAC_SM_W_NR    = 10'h015;
  localparam cnt_t MAC_MS_B       = 10'h016;
  localparam cnt_t MAC_MS_B_NR    = 10'h014;
  localparam cnt_t MAC_MS_W       = 10'h016;
  localparam cnt_t MAC_SS         = 10'h01B;
  localparam cnt_t MAC_SMS        = 10'h025;
  localparam cnt_t MAC_SMS_NR     = 10'h022;
  localparam cnt_t ROT_REG_BASE   = 10'h009;
  localparam cnt_t ROT_MEM_B      = 10'h00D;
  localparam cnt_t ROT_MEM_B_NR   = 10'h00B;
  localparam cnt_t ROT_MEM_W      = 10'h011;
  localparam cnt_t ROT_MEM_W_NR   = 10'h00D;

endpackage

// ---- logic/svc_down_counter.sv ----
`timescale 1ns/100ps
module svc_down_counter #(
  parameter int CNT_W = 10
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Load port.
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_value,
  // State.
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_busy,
  output logic                  o_last
);

  localparam logic [CNT_W-1:0] ZERO = '0;
  localparam logic [CNT_W-1:0] ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  logic [CNT_W-1:0] cnt_r;

  // A load of L keeps the counter busy for exactly L cycles.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= ZERO;
    end else if (i_load) begin
      cnt_r <= i_value;
    end else if (cnt_r != ZERO) begin
      cnt_r <= cnt_r - ONE;
    end
  end

  // Outputs show the clocks still to run, including the present one.
  assign o_count = cnt_r;
  assign o_busy  = (cnt_r != ZERO);
  assign o_last  = (cnt_r == ONE);

endmodule

// ---- logic/cpu_service_timing_model.sv ----
`timescale 1ns/100ps
// Functional notes
// RULE_01: Maskable interrupt latency is 27 plus N.
// RULE_02: Non-maskable interrupt latency is 18 plus N.
// RULE_03: N is clocks left in current instruction.
// RULE_04: External interrupt flag set within 6 clocks.
// RULE_05: Internal interrupt flag set within 2 clocks.
// RULE_06: DMA and macro counts are per transfer.
// RULE_07: Vectored interrupt service takes 58 plus 10W.
// RULE_08: Context switch service takes 27 clocks flat.
// RULE_09: Single-step DMA: byte 20+2W, word 24+4W.
// RULE_10: Demand-release DMA: byte 15+W, word 17+2W.
// RULE_11: Macro register to memory: 24/19 plus W.
// RULE_12: Macro memory to register: 22/20, word 22+2W.
// RULE_13: Search register to memory: 27+W, bytes only.
// RULE_14: Search memory to register: 37/34+W, bytes only.
// RULE_15: DMA request latency 29+N, single transfer 31+N.
// RULE_16: Register rotate by immediate takes 9+2n.
// RULE_17: W equals programmed wait_control_register value.
// RULE_18: RAM disabled selects the alternate count.
// RULE_19: Effective address adds 3 or 4 clocks.
// RULE_20: Response is sync, arbitration, N, then service.
module cpu_service_timing_model (
  // Clock and reset.
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  // Configuration.
  input  wire svc_timing_pkg::cfg_t i_cfg,
  input  wire logic                 i_ctx_switch,
  // Instruction issue.
  input  wire svc_timing_pkg::instr_t i_instr,
  output logic                      o_instr_ready,
  output logic                      o_instr_done,
  output svc_timing_pkg::cnt_t      o_instr_clocks,
  // Interrupt sources.
  input  wire logic                 i_ext_int,
  input  wire logic                 i_nmi,
  input  wire logic                 i_int_event,
  output logic                      o_ext_flag,
  output logic                      o_nmi_flag,
  output logic                      o_int_flag,
  // DMA and macro service requests.
  input  wire svc_timing_pkg::dma_t   i_dma,
  input  wire svc_timing_pkg::macro_t i_macro,
  // Service status.
  output logic                      o_in_latency,
  output logic                      o_in_service,
  output svc_timing_pkg::svc_t      o_service_kind,
  output logic                      o_service_start,
  output logic                      o_dma_cycle_start,
  output logic                      o_service_done,
  output svc_timing_pkg::cnt_t      o_service_clocks,
  output svc_timing_pkg::cnt_t      o_resp_clocks
);
  import svc_timing_pkg::*;

  // ----------------------------------------------------------------
  // Count functions
  // ----------------------------------------------------------------
  function automatic cnt_t ws_mul(cfg_t c, cnt_t f);
    return cnt_t'(c.wait_states) * f; // RULE_17
  endfunction

  function automatic cnt_t ea_clocks(logic [1:0] md);
    return (md == MOD_DISP16) ? EA_LONG : EA_SHORT; // RULE_19
  endfunction

  function automatic cnt_t instr_clocks(instr_t i, cfg_t c);
    cnt_t two_n;
    cnt_t r;
    two_n = cnt_t'({i.rot_count, 1'b0});
    r = i.clocks;
    case (i.kind)
      INS_ROT_REG: r = ROT_REG_BASE + two_n; // RULE_16
      INS_ROT_MEM: begin
        if (i.wide) begin
          r = c.ram_enable ? ROT_MEM_W + ws_mul(c, W_X4) : ROT_MEM_W_NR + ws_mul(c, W_X2); // RULE_18
        end else begin
          r = c.ram_enable ? ROT_MEM_B + ws_mul(c, W_X2) : ROT_MEM_B_NR + ws_mul(c, W_X1);
        end
        r = r + ea_clocks(i.mod) + two_n; // RULE_19
      end
      default: r = i.clocks;
    endcase
    return r;
  endfunction

  // Each DMA and macro figure covers one transfer only.
  function automatic cnt_t svc_clocks(svc_t k, cfg_t c, dma_t d, macro_t m, logic ctx);
    cnt_t r;
    r = CNT_ZERO;
    case (k)
      SVC_NMI: r = VEC_BASE + ws_mul(c, VEC_PER_W); // RULE_07
      SVC_EXT: r = PIN_BASE + ws_mul(c, PIN_PER_W);
      SVC_INT: r = ctx ? CTX_CLK : VEC_BASE + ws_mul(c, VEC_PER_W); // RULE_08
      SVC_DMA: begin
        case (d.mode)
          DMA_SINGLE_STEP: r = d.word ? DMA_SS_W + ws_mul(c, W_X4) : DMA_SS_B + ws_mul(c, W_X2); // RULE_09
          DMA_DEMAND:      r = d.word ? DMA_DR_W + ws_mul(c, W_X2) : DMA_DR_B + ws_mul(c, W_X1); // RULE_10
          DMA_BURST:       r = DMA_BU + ws_mul(c, d.word ? W_X4 : W_X2); // RULE_06
          default:         r = d.word ? DMA_SX_W + ws_mul(c, W_X2) : DMA_SX_B + ws_mul(c, W_X1);
        endcase
      end
      SVC_MACRO: begin
        case (m.kind)
          MAC_SFR_MEM: begin
            if (m.word) begin
              r = (c.ram_enable ? MAC_SM_W : MAC_SM_W_NR) + ws_mul(c, W_X2); // RULE_11
            end else begin
              r = (c.ram_enable ? MAC_SM_B : MAC_SM_B_NR) + ws_mul(c, W_X1);
            end
          end
          MAC_MEM_SFR: begin
            if (m.word) begin
              r = MAC_MS_W + ws_mul(c, W_X2); // RULE_12
            end else begin
              r = (c.ram_enable ? MAC_MS_B : MAC_MS_B_NR) + ws_mul(c, W_X1);
            end
          end
          MAC_SRCH_SFR_MEM: r = MAC_SS + ws_mul(c, W_X1); // RULE_13
          default:          r = (c.ram_enable ? MAC_SMS : MAC_SMS_NR) + ws_mul(c, W_X1); // RULE_14
        endcase
      end
      default: r = CNT_ZERO;
    endcase
    return r;
  endfunction

  function automatic cnt_t lat_base(svc_t k, dma_mode_t md);
    cnt_t r;
    r = LAT_MASKABLE; // RULE_01
    case (k)
      SVC_NMI: r = LAT_NMI; // RULE_02
      SVC_DMA: r = (md == DMA_SINGLE_XFER) ? LAT_DMA_SINGLE : LAT_DMA; // RULE_15
      default: r = LAT_MASKABLE;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  state_t st_r;
  state_t st_nxt;
  svc_t   kind_r;
  cfg_t   cfg_r;
  dma_t   dma_r;
  macro_t mac_r;
  logic   ctx_r;
  cnt_t   n_cap_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic   int_ev_r;
  logic   ext_flag_r;
  logic   nmi_flag_r;
  logic   int_flag_r;
  logic   start_r;
  logic   dma_start_r;
  cnt_t   svc_clk_r;
  cnt_t   ins_clk_r;
  cnt_t   resp_r;
  cnt_t   resp_out_r;
  cnt_t   ins_cnt;
  logic   ins_busy;
  logic   ins_last;
  logic   ph_last;
  cnt_t   ph_cnt;
  logic   ph_busy;

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  wire [1:0] pin_rise  = pin_s2_r & ~pin_s3_r;
  wire       any_pend  = nmi_flag_r | i_dma.req | i_macro.req | ext_flag_r | int_flag_r;
  wire svc_t sel       = nmi_flag_r ? SVC_NMI : i_dma.req ? SVC_DMA : i_macro.req ? SVC_MACRO :
                         ext_flag_r ? SVC_EXT : int_flag_r ? SVC_INT : SVC_NONE;
  wire       st_idle   = (st_r == ST_IDLE);
  wire       st_lat    = (st_r == ST_LAT);
  wire       st_serv   = (st_r == ST_SERV);
  wire       go_lat    = st_idle & any_pend;
  wire       serv_done = st_serv & ph_last;
  wire       burst_again = serv_done & (kind_r == SVC_DMA) & (dma_r.mode == DMA_BURST) & i_dma.req & ~nmi_flag_r;
  wire       go_serv   = (st_lat & ph_last) | burst_again;

  // Pins pass two flip-flops, then an edge stage sets the flag.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
      int_ev_r <= 1'b0;
    end else begin
      pin_s1_r <= {i_nmi, i_ext_int};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      int_ev_r <= i_int_event;
    end
  end

  // Setting wins over the clear made when a request is accepted.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_flag_r <= 1'b0;
      nmi_flag_r <= 1'b0;
      int_flag_r <= 1'b0;
    end else begin
      ext_flag_r <= pin_rise[PIN_EXT] | (ext_flag_r & ~(go_lat & (sel == SVC_EXT))); // RULE_04
      nmi_flag_r <= pin_rise[PIN_NMI] | (nmi_flag_r & ~(go_lat & (sel == SVC_NMI)));
      int_flag_r <= int_ev_r | (int_flag_r & ~(go_lat & (sel == SVC_INT))); // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // Instruction timing
  // ----------------------------------------------------------------
  wire  cnt_t ins_val  = instr_clocks(i_instr, i_cfg);
  wire        ins_load = i_instr.start & o_instr_ready & (ins_val != CNT_ZERO);
  // Clocks still needed by the running instruction after this edge.
  wire  cnt_t n_remain = ins_busy ? ins_cnt - CNT_ONE : CNT_ZERO; // RULE_03

  svc_down_counter #(.CNT_W(CNT_W)) u_instr_cnt (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (ins_load),
    .i_value   (ins_val),
    .o_count   (ins_cnt),
    .o_busy    (ins_busy),
    .o_last    (ins_last)
  );

  // ----------------------------------------------------------------
  // Service sequencer
  // ----------------------------------------------------------------
  // Latency counts the decision cycle, so the phase runs one short.
  wire cnt_t lat_val = lat_base(sel, i_dma.mode) - CNT_ONE + n_remain; // RULE_20
  wire cnt_t svc_val = svc_clocks(kind_r, cfg_r, dma_r, mac_r, ctx_r);
  wire       ph_load = go_lat | go_serv;
  wire cnt_t ph_val  = go_lat ? lat_val : svc_val;

  svc_down_counter #(.CNT_W(CNT_W)) u_phase_cnt (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (ph_load),
    .i_value   (ph_val),
    .o_count   (ph_cnt),
    .o_busy    (ph_busy),
    .o_last    (ph_last)
  );

  // Next state.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (any_pend) st_nxt = ST_LAT;
      ST_LAT:  if (ph_last) st_nxt = ST_SERV;
      ST_SERV: if (ph_last && !burst_again) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Request context is frozen when the request is accepted.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      kind_r  <= SVC_NONE;
      cfg_r   <= '0;
      dma_r   <= '0;
      mac_r   <= '0;
      ctx_r   <= 1'b0;
      n_cap_r <= CNT_ZERO;
    end else if (go_lat) begin
      kind_r  <= sel;
      cfg_r   <= i_cfg;
      dma_r   <= i_dma;
      mac_r   <= i_macro;
      ctx_r   <= i_ctx_switch;
      n_cap_r <= n_remain;
    end
  end

  // Start pulses and figures shown to the outside.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_r     <= 1'b0;
      dma_start_r <= 1'b0;
      svc_clk_r   <= CNT_ZERO;
      ins_clk_r   <= CNT_ZERO;
    end else begin
      start_r     <= go_serv;
      dma_start_r <= go_serv & (kind_r == SVC_DMA);
      svc_clk_r   <= go_serv ? svc_val : svc_clk_r;
      ins_clk_r   <= ins_load ? ins_val : ins_clk_r;
    end
  end

  // Response clocks run from flag set until the service ends.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      resp_r     <= CNT_ZERO;
      resp_out_r <= CNT_ZERO;
    end else if (serv_done) begin
      resp_r     <= CNT_ZERO;
      resp_out_r <= resp_r + CNT_ONE; // RULE_20
    end else if (any_pend || !st_idle) begin
      resp_r     <= resp_r + CNT_ONE;
    end
  end

  assign o_instr_ready     = st_idle & ~ins_busy & ~any_pend;
  assign o_instr_done      = ins_last;
  assign o_instr_clocks    = ins_clk_r;
  assign o_ext_flag        = ext_flag_r;
  assign o_nmi_flag        = nmi_flag_r;
  assign o_int_flag        = int_flag_r;
  assign o_in_latency      = st_lat;
  assign o_in_service      = st_serv;
  assign o_service_kind    = kind_r;
  assign o_service_start   = start_r;
  assign o_dma_cycle_start = dma_start_r;
  assign o_service_done    = serv_done;
  assign o_service_clocks  = svc_clk_r;
  assign o_resp_clocks     = resp_out_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int SYNC_EXT_MAX = 6;
  localparam int SYNC_INT_MAX = 2;

  cnt_t        len_r;
  cnt_t        ins_len_r;
  instr_t      ins_r;
  cfg_t        ins_cfg_r;

  // Cycle counts of the current phase and instruction.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      len_r     <= CNT_ZERO;
      ins_len_r <= CNT_ZERO;
      ins_r     <= '0;
      ins_cfg_r <= '0;
    end else begin
      len_r     <= ph_load ? CNT_ONE : len_r + CNT_ONE;
      ins_len_r <= ins_load ? CNT_ONE : ins_len_r + CNT_ONE;
      ins_r     <= ins_load ? i_instr : ins_r;
      ins_cfg_r <= ins_load ? i_cfg : ins_cfg_r;
    end
  end

  wire cnt_t wv   = cnt_t'(cfg_r.wait_states);
  wire cnt_t iwv  = cnt_t'(ins_cfg_r.wait_states);
  wire cnt_t i2n  = cnt_t'({ins_r.rot_count, 1'b0});
  wire       rmem = ins_r.kind == INS_ROT_MEM;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_lat_end;
    st_lat && ph_last;
  endsequence

  sequence s_serv_begin;
    st_serv && o_service_start && len_r == CNT_ONE;
  endsequence

  a_ext_flag_sync: assert property ($rose(i_ext_int) |-> ##[1:SYNC_EXT_MAX] ext_flag_r) // RULE_04
    else $error("external flag late");
  a_int_flag_set: assert property (i_int_event |-> ##[1:SYNC_INT_MAX] int_flag_r) // RULE_05
    else $error("internal flag late");
  a_mask_latency: assert property (s_lat_end ##0 (kind_r inside {SVC_EXT, SVC_INT, SVC_MACRO}) // RULE_01 RULE_03
    |-> len_r + CNT_ONE == LAT_MASKABLE + n_cap_r) else $error("maskable latency wrong");
  a_nmi_latency: assert property (s_lat_end ##0 kind_r == SVC_NMI // RULE_02
    |-> len_r + CNT_ONE == LAT_NMI + n_cap_r) else $error("nmi latency wrong");
  a_dma_latency: assert property (s_lat_end ##0 kind_r == SVC_DMA // RULE_15
    |-> len_r + CNT_ONE == ((dma_r.mode == DMA_SINGLE_XFER) ? LAT_DMA_SINGLE : LAT_DMA) + n_cap_r)
    else $error("dma latency wrong");
  a_lat_then_serv: assert property (s_lat_end |=> s_serv_begin) // RULE_20
    else $error("service did not follow latency");
  a_burst_per_xfer: assert property (burst_again |=> s_serv_begin ##0 o_dma_cycle_start) // RULE_06
    else $error("burst transfer not restarted");
  a_vector_service: assert property (serv_done && (kind_r == SVC_NMI || (kind_r == SVC_INT && !ctx_r)) // RULE_07
    |-> len_r == VEC_BASE + wv * VEC_PER_W) else $error("vectored service length wrong");
  a_ctx_service: assert property (serv_done && kind_r == SVC_INT && ctx_r |-> len_r == CTX_CLK) // RULE_08
    else $error("context switch length wrong");
  a_dma_step_len: assert property (serv_done && kind_r == SVC_DMA && dma_r.mode == DMA_SINGLE_STEP // RULE_09
    |-> len_r == (dma_r.word ? DMA_SS_W + W_X4 * wv : DMA_SS_B + W_X2 * wv)) else $error("single-step length wrong");
  a_dma_demand_len: assert property (serv_done && kind_r == SVC_DMA && dma_r.mode == DMA_DEMAND // RULE_10
    |-> len_r == (dma_r.word ? DMA_DR_W + W_X2 * wv : DMA_DR_B + wv)) else $error("demand-release length wrong");
  a_macro_to_mem: assert property (serv_done && kind_r == SVC_MACRO && mac_r.kind == MAC_SFR_MEM // RULE_11 RULE_18
    && !mac_r.word |-> len_r == (cfg_r.ram_enable ? MAC_SM_B : MAC_SM_B_NR) + wv)
    else $error("register to memory length wrong");
  a_macro_to_sfr: assert property (serv_done && kind_r == SVC_MACRO && mac_r.kind == MAC_MEM_SFR // RULE_12
    |-> len_r == (mac_r.word ? MAC_MS_W + W_X2 * wv : (cfg_r.ram_enable ? MAC_MS_B : MAC_MS_B_NR) + wv))
    else $error("memory to register length wrong");
  a_search_to_mem: assert property (serv_done && kind_r == SVC_MACRO && mac_r.kind == MAC_SRCH_SFR_MEM // RULE_13
    |-> len_r == MAC_SS + wv) else $error("search to memory length wrong");
  a_search_to_sfr: assert property (serv_done && kind_r == SVC_MACRO && mac_r.kind == MAC_SRCH_MEM_SFR // RULE_14
    |-> len_r == (cfg_r.ram_enable ? MAC_SMS : MAC_SMS_NR) + wv) else $error("search to register length wrong");
  a_rotate_reg_len: assert property (ins_last && ins_r.kind == INS_ROT_REG // RULE_16
    |-> ins_len_r == ROT_REG_BASE + i2n) else $error("register rotate length wrong");
  a_rotate_mem_len: assert property (ins_last && rmem && ins_r.wide && ins_cfg_r.ram_enable // RULE_19 RULE_17
    |-> ins_len_r == ((ins_r.mod == MOD_DISP16) ? EA_LONG : EA_SHORT) + ROT_MEM_W + W_X4 * iwv + i2n)
    else $error("memory rotate length wrong");

endmodule

// ---- sim/svc_requester.sv ----
`timescale 1ns/100ps
// Requester for DMA and macro service; holds req until its service starts.
module svc_requester (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_fire,
  input  wire logic                   i_sel,
  input  wire logic                   i_start,
  input  wire logic [1:0]             i_mode,
  input  wire logic                   i_word,
  output svc_timing_pkg::dma_t        o_dma,
  output svc_timing_pkg::macro_t      o_macro
);
  import svc_timing_pkg::*;
  logic       req_r;
  logic       sel_r;
  logic       word_r;
  logic [1:0] mode_r;
  // One transfer per request, so the req drops once service has begun.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_r  <= 1'h0;
      sel_r  <= 1'h0;
      mode_r <= 2'h0;
      word_r <= 1'h0;
    end else if (i_fire) begin
      req_r  <= 1'h1;
      sel_r  <= i_sel;
      mode_r <= i_mode;
      word_r <= i_word;
    end else if (i_start) begin
      req_r <= 1'h0;
    end
  end
  // An idle requester shows the inverse of its last qualifiers.
  assign o_dma   = (req_r && !sel_r) ? {1'h1, mode_r, word_r} : {1'h0, ~mode_r, ~word_r};
  assign o_macro = (req_r && sel_r) ? {1'h1, mode_r, word_r} : {1'h0, ~mode_r, ~word_r};
endmodule

// ---- sim/cpu_service_timing_model_tb_top.sv ----
`timescale 1ns/100ps
module cpu_service_timing_model_tb_top;
  import svc_timing_pkg::*;
  typedef struct packed {
    svc_t sk; logic [1:0] md; logic wd; logic [1:0] ws; logic rm; logic cx; cnt_t bs; cnt_t sv;
  } row_t;
  logic   i_clk, i_reset_n, ctx, ext, nmi, iev, fire, sel, word, rdy, idone, ef, nf, itf, lat, srv, sst, dst, sdone;
  logic [1:0] mode;
  cfg_t   cfg;
  instr_t instr;
  dma_t   dma;
  macro_t mac;
  cnt_t   iclk, sclk, rclk;
  svc_t   skind;
  int     bad_count, n_compared, n;
  // Request kind, mode, word, W, RAM, context switch, latency base, service clocks.
  row_t rows [16] = '{
    '{SVC_NMI, 2'h0, 1'h0, 2'h2, 1'h1, 1'h0, 10'h012, 10'h04E},
    '{SVC_DMA, 2'h0, 1'h0, 2'h1, 1'h1, 1'h0, 10'h01D, 10'h016},
    '{SVC_DMA, 2'h0, 1'h1, 2'h1, 1'h1, 1'h0, 10'h01D, 10'h01C},
    '{SVC_DMA, 2'h1, 1'h0, 2'h2, 1'h1, 1'h0, 10'h01D, 10'h011},
    '{SVC_DMA, 2'h1, 1'h1, 2'h3, 1'h1, 1'h0, 10'h01D, 10'h017},
    '{SVC_DMA, 2'h2, 1'h1, 2'h1, 1'h1, 1'h0, 10'h01D, 10'h010},
    '{SVC_DMA, 2'h3, 1'h0, 2'h1, 1'h1, 1'h0, 10'h01F, 10'h022},
    '{SVC_MACRO, 2'h0, 1'h0, 2'h1, 1'h1, 1'h0, 10'h01B, 10'h019},
    '{SVC_MACRO, 2'h0, 1'h1, 2'h1, 1'h0, 1'h0, 10'h01B, 10'h017},
    '{SVC_MACRO, 2'h1, 1'h0, 2'h0, 1'h0, 1'h0, 10'h01B, 10'h014},
    '{SVC_MACRO, 2'h1, 1'h1, 2'h1, 1'h1, 1'h0, 10'h01B, 10'h018},
    '{SVC_MACRO, 2'h2, 1'h0, 2'h2, 1'h1, 1'h0, 10'h01B, 10'h01D},
    '{SVC_MACRO, 2'h3, 1'h0, 2'h1, 1'h0, 1'h0, 10'h01B, 10'h023},
    '{SVC_EXT, 2'h0, 1'h0, 2'h1, 1'h1, 1'h0, 10'h01B, 10'h044},
    '{SVC_INT, 2'h0, 1'h0, 2'h1, 1'h1, 1'h0, 10'h01B, 10'h044},
    '{SVC_INT, 2'h0, 1'h0, 2'h3, 1'h0, 1'h1, 10'h01B, 10'h01B}};
  cpu_service_timing_model u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg(cfg), .i_ctx_switch(ctx),
    .i_instr(instr), .o_instr_ready(rdy), .o_instr_done(idone), .o_instr_clocks(iclk), .i_ext_int(ext),
    .i_nmi(nmi), .i_int_event(iev), .o_ext_flag(ef), .o_nmi_flag(nf), .o_int_flag(itf), .i_dma(dma),
    .i_macro(mac), .o_in_latency(lat), .o_in_service(srv), .o_service_kind(skind), .o_service_start(sst),
    .o_dma_cycle_start(dst), .o_service_done(sdone), .o_service_clocks(sclk), .o_resp_clocks(rclk));
  svc_requester u_req (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_fire(fire), .i_sel(sel), .i_start(sst),
    .i_mode(mode), .i_word(word), .o_dma(dma), .o_macro(mac));
  // Free-running 50 MHz clock.
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Fires one request and checks flag delay, service length and response total.
  task run(input row_t r);
    @(posedge i_clk);
    cfg <= {r.ws, r.rm};
    ctx <= r.cx;
    @(posedge i_clk);
    nmi <= (r.sk == SVC_NMI);
    ext <= (r.sk == SVC_EXT);
    iev <= (r.sk == SVC_INT);
    fire <= (r.sk == SVC_DMA) || (r.sk == SVC_MACRO);
    sel <= (r.sk == SVC_MACRO);
    mode <= r.md;
    word <= r.wd;
    @(negedge i_clk);
    n = 1;
    @(posedge i_clk);
    iev <= 1'h0;
    fire <= 1'h0;
    while (!(nf || ef || itf || lat) && n < 9) begin @(negedge i_clk); n++; end
    if (r.sk == SVC_INT) check(n - 1 <= 2, 16'h0001);
    else if (r.sk == SVC_NMI || r.sk == SVC_EXT) check(n - 1 <= 6, 16'h0001);
    while (!sdone && n < 400) begin @(negedge i_clk); n++; end
    check(sclk, r.sv);
    check({sdone, skind}, {1'h1, r.sk});
    @(negedge i_clk);
    check(rclk, r.bs + r.sv);
    @(posedge i_clk);
    nmi <= 1'h0;
    ext <= 1'h0;
  endtask
  task do_instr(input cfg_t c, input instr_t v, input cnt_t e);
    @(posedge i_clk);
    cfg <= c;
    instr <= v;
    @(posedge i_clk);
    instr.start <= 1'h0;
    @(negedge i_clk);
    n = 1;
    while (!idone && n < 300) begin @(negedge i_clk); n++; end
    check(16'(n), e);
    check(iclk, e);
  endtask
  // Main sequence: reset, table of services, rotates, burst DMA, then NMI behind a long instruction.
  initial begin
    {i_reset_n, ctx, ext, nmi, iev, fire, sel, mode, word, cfg, instr} = '0;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'h1;
    @(negedge i_clk);
    check(rdy, 16'h0001);
    check({skind, srv, lat}, 16'h0000);
    foreach (rows[i]) run(rows[i]);
    do_instr({2'h1, 1'h1}, {1'h1, INS_ROT_REG, 1'h0, 2'h3, 5'h03, 10'h000}, 10'h00F);
    do_instr({2'h1, 1'h1}, {1'h1, INS_ROT_MEM, 1'h0, 2'h2, 5'h02, 10'h000}, 10'h017);
    do_instr({2'h1, 1'h1}, {1'h1, INS_ROT_MEM, 1'h1, 2'h0, 5'h01, 10'h000}, 10'h01A);
    do_instr({2'h2, 1'h0}, {1'h1, INS_ROT_MEM, 1'h0, 2'h1, 5'h01, 10'h000}, 10'h012);
    // Burst DMA: a request raised again during a transfer gets the next one with no latency.
    @(posedge i_clk);
    {fire, sel, mode, word} <= {1'h1, 1'h0, 2'h2, 1'h0};
    @(posedge i_clk);
    fire <= 1'h0;
    n = 0;
    while (!sst && n < 60) begin @(negedge i_clk); n++; end
    @(posedge i_clk);
    fire <= 1'h1;
    @(posedge i_clk);
    fire <= 1'h0;
    while (!sdone && n < 99) begin @(negedge i_clk); n++; end
    @(negedge i_clk);
    check({sst, dst, srv, lat}, 16'h000E);
    check(sclk, 16'h0010);
    while (!sdone && n < 199) begin @(negedge i_clk); n++; end
    @(posedge i_clk);
    instr <= {1'h1, INS_PLAIN, 1'h0, 2'h0, 5'h00, 10'h028};
    @(posedge i_clk);
    instr.start <= 1'h0;
    nmi <= 1'h1;
    n = 0;
    while (!idone && n < 60) begin @(negedge i_clk); n++; end
    n = 0;
    while (!sst && n < 60) begin @(negedge i_clk); n++; end
    check(16'(n), 16'h0012);
    while (!sdone && n < 300) begin @(negedge i_clk); n++; end
    check({sdone, sclk}, {1'h1, 10'h04E});
    wrap_up();
  end
  // Watchdog cuts a hang short.
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
endmodule
